// File: design/pcm_pkg.sv
// Constants and types for the port C alternate function mux
// Overview of operation
// R1: Each port bit drives its own pin-change line, bit 0 to line 8 up to 15.
// R2: Bit 3 feeds timer 1 clock, CAN receive and timer 1 alternate capture.
// R3: Bit 2 feeds timer 0 clock and carries CAN transmit data.
// R4: Software sets bit 1 direction before compare B can drive the pin.
// R5: Bit 1 carries timer 1 compare B waveform output, including PWM mode.
// R6: SPI slave on alternate select forces bit 1 to input.
// R7: SPI slave active only while alternate select pin is low.
// R8: SPI master leaves bit 1 direction to its direction register bit.
// R9: Pull-up on forced-input select pin still follows port output bit.
// R10: Bit 0 is the source of external interrupt three.
// R11: Bit 0 carries power stage output 1A waveform.
// R12: Bit 1 level goes to power stage digital input 1.
// R13: Software keeps analog pins as inputs with pull-ups off.
// R14: DAC enable forces bit 7 input and overrides its digital input enable.
// R15: Power stage 1A enable forces bit 0 output; interrupt enable forces input on.
package pcm_pkg;

  // ---------------------------------------------------------------
  // Pin positions and reset values
  // ---------------------------------------------------------------
  localparam int          PCM_WIDTH      = 8;
  localparam int          PCM_PCINT_BASE = 8;
  localparam int          PCM_BIT_PSC    = 0;
  localparam int          PCM_BIT_SS     = 1;
  localparam int          PCM_BIT_CANTX  = 2;
  localparam int          PCM_BIT_CANRX  = 3;
  localparam int          PCM_BIT_DAC    = 7;
  localparam logic [7:0]  PCM_PIN_RESET  = 8'h00;
  localparam logic [7:0]  PCM_PCI_RESET  = 8'h00;

  // Port register view seen by the mux
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] out;
    logic       pud;
  } pcm_port_t;

  // Peripheral controls
  typedef struct packed {
    logic spi_en;
    logic spi_master;
    logic spi_alt;
    logic timer_one_compare_b_output_en;
    logic timer_one_compare_b_output_val;
    logic psc_en;
    logic psc_val;
    logic external_interrupt_three_en;
    logic can_tx_en;
    logic can_tx_val;
    logic dac_en;
    logic [7:0] adc_dis;
  } pcm_periph_t;

  // Synchronised inputs toward peripherals
  typedef struct packed {
    logic t1_clk;
    logic t0_clk;
    logic can_rx;
    logic timer_one_capture_alt_input;
    logic external_interrupt_three;
    logic psc_in1;
    logic ss_n;
    logic spi_sel;
  } pcm_in_t;

endpackage

// File: design/pcm_sync.sv
// Two-flop synchroniser for the port pins
`timescale 1ns/10ps
module pcm_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             CLOCK_I,
  input  wire logic             RESET_I,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  import pcm_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pcm_sync_t;

  pcm_sync_t st_reg;
  pcm_sync_t st_next;

  initial
  begin
    if (WIDTH < 1)
      $error("pcm_sync width must be positive");
  end

  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q_o = st_reg.s2;
endmodule

// File: design/pcm_mux.sv
// Port C alternate function mux top
`timescale 1ns/10ps
module pcm_mux (
  input  wire logic                CLOCK_I,
  input  wire logic                RESET_I,
  input  wire pcm_pkg::pcm_port_t  PORT_I,
  input  wire pcm_pkg::pcm_periph_t PERIPH_I,
  input  wire logic [7:0]          PIN_I,
  output logic      [7:0]          PIN_O,
  output logic      [7:0]          PIN_OE_O,
  output logic      [7:0]          PULLUP_O,
  output logic      [7:0]          DIN_EN_O,
  output logic      [7:0]          PIN_VALUE_O,
  output logic      [7:0]          PIN_CHANGE_O,
  output pcm_pkg::pcm_in_t         PERIPH_IN_O
);
  import pcm_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pin_o;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] die;
    logic [7:0] prev;
    logic [7:0] pchg;
    pcm_in_t    pin;
  } pcm_state_t;

  pcm_state_t st_reg;
  pcm_state_t st_next;
  logic [7:0] pin_sync;
  logic       ss_force_in;
  logic       spi_slave;

  pcm_sync #(.WIDTH(PCM_WIDTH)) u_sync (
    .CLOCK_I (CLOCK_I),
    .RESET_I (RESET_I),
    .d_i     (PIN_I),
    .q_o     (pin_sync)
  );

  // ---------------------------------------------------------------
  // Override logic
  // ---------------------------------------------------------------
  assign spi_slave   = PERIPH_I.spi_en & ~PERIPH_I.spi_master;
  assign ss_force_in = spi_slave & PERIPH_I.spi_alt; // R6

  always_comb
  begin
    st_next = st_reg;
    for (int i = 0; i < PCM_WIDTH; i++)
    begin
      st_next.oe[i]    = PORT_I.dir[i]; // R8
      st_next.pin_o[i] = PORT_I.out[i];
      st_next.pu[i]    = ~PORT_I.dir[i] & PORT_I.out[i] & ~PORT_I.pud;
      st_next.die[i]   = ~PERIPH_I.adc_dis[i];
    end
    // Bit 0: power stage output and interrupt three
    if (PERIPH_I.psc_en)
    begin
      st_next.oe[PCM_BIT_PSC]    = 1'b1; // R15
      st_next.pin_o[PCM_BIT_PSC] = PERIPH_I.psc_val; // R11
    end
    if (PERIPH_I.external_interrupt_three_en)
      st_next.die[PCM_BIT_PSC] = 1'b1; // R15
    // Bit 1: compare B output, direction from software
    if (PERIPH_I.timer_one_compare_b_output_en)
      st_next.pin_o[PCM_BIT_SS] = PERIPH_I.timer_one_compare_b_output_val; // R5 R4
    if (ss_force_in)
    begin
      st_next.oe[PCM_BIT_SS] = 1'b0; // R6
      st_next.pu[PCM_BIT_SS] = PORT_I.out[PCM_BIT_SS] & ~PORT_I.pud; // R9
    end
    // Master mode keeps direction register control (R8)
    // Bit 2: CAN transmit
    if (PERIPH_I.can_tx_en)
    begin
      st_next.oe[PCM_BIT_CANTX]    = 1'b1; // R3
      st_next.pin_o[PCM_BIT_CANTX] = PERIPH_I.can_tx_val; // R3
    end
    // Bit 7: DAC output
    if (PERIPH_I.dac_en)
    begin
      st_next.oe[PCM_BIT_DAC]  = 1'b0; // R14
      st_next.die[PCM_BIT_DAC] = 1'b0; // R14
      st_next.pu[PCM_BIT_DAC]  = 1'b0;
    end
    // Inputs toward peripherals
    st_next.pin.t1_clk  = pin_sync[PCM_BIT_CANRX]; // R2
    st_next.pin.can_rx  = pin_sync[PCM_BIT_CANRX]; // R2
    st_next.pin.timer_one_capture_alt_input   = pin_sync[PCM_BIT_CANRX]; // R2
    st_next.pin.t0_clk  = pin_sync[PCM_BIT_CANTX]; // R3
    st_next.pin.external_interrupt_three    = pin_sync[PCM_BIT_PSC]; // R10
    st_next.pin.psc_in1 = pin_sync[PCM_BIT_SS]; // R12
    st_next.pin.ss_n    = pin_sync[PCM_BIT_SS];
    st_next.pin.spi_sel = ss_force_in & ~pin_sync[PCM_BIT_SS]; // R7
    // Pin change lines 8..15
    st_next.prev = pin_sync;
    st_next.pchg = pin_sync ^ st_reg.prev; // R1
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      st_reg      <= '0;
      st_reg.pchg <= PCM_PCI_RESET;
      st_reg.prev <= PCM_PIN_RESET;
    end
    else
      st_reg <= st_next;
  end

  assign PIN_O        = st_reg.pin_o;
  assign PIN_OE_O     = st_reg.oe;
  assign PULLUP_O     = st_reg.pu;
  assign DIN_EN_O     = st_reg.die;
  assign PIN_VALUE_O  = pin_sync;
  assign PIN_CHANGE_O = st_reg.pchg; // R1
  assign PERIPH_IN_O  = st_reg.pin;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_pchg;
    @(posedge CLOCK_I) disable iff (RESET_I)
      ##1 PIN_CHANGE_O == ($past(pin_sync) ^ $past(pin_sync, 2));
  endproperty
  a_pchg: assert property (p_pchg) else $error("pin change wrong"); // R1

  property p_canrx;
    @(posedge CLOCK_I) disable iff (RESET_I)
      ##1 (PERIPH_IN_O.can_rx == $past(pin_sync[3]))
        && (PERIPH_IN_O.t1_clk == PERIPH_IN_O.timer_one_capture_alt_input);
  endproperty
  a_canrx: assert property (p_canrx) else $error("bit 3 route wrong"); // R2

  property p_cantx;
    @(posedge CLOCK_I) disable iff (RESET_I)
      PERIPH_I.can_tx_en |=> PIN_OE_O[2]
        && PIN_O[2] == $past(PERIPH_I.can_tx_val);
  endproperty
  a_cantx: assert property (p_cantx) else $error("can tx wrong"); // R3

  property p_timer_one_compare_b_output;
    @(posedge CLOCK_I) disable iff (RESET_I)
      PERIPH_I.timer_one_compare_b_output_en |=> PIN_O[1] == $past(PERIPH_I.timer_one_compare_b_output_val);
  endproperty
  a_timer_one_compare_b_output: assert property (p_timer_one_compare_b_output) else $error("compare B wrong"); // R5

  property p_ssin;
    @(posedge CLOCK_I) disable iff (RESET_I)
      ss_force_in |=> !PIN_OE_O[1]
        && PULLUP_O[1] == $past(PORT_I.out[1] & ~PORT_I.pud);
  endproperty
  a_ssin: assert property (p_ssin) else $error("select not input"); // R6 R9

  property p_sssel;
    @(posedge CLOCK_I) disable iff (RESET_I)
      (ss_force_in && pin_sync[1]) |=> !PERIPH_IN_O.spi_sel;
  endproperty
  a_sssel: assert property (p_sssel) else $error("slave active high"); // R7

  property p_master;
    @(posedge CLOCK_I) disable iff (RESET_I)
      (PERIPH_I.spi_en && PERIPH_I.spi_master)
        |=> PIN_OE_O[1] == $past(PORT_I.dir[1]);
  endproperty
  a_master: assert property (p_master) else $error("master dir wrong"); // R8

  property p_external_interrupt_three;
    @(posedge CLOCK_I) disable iff (RESET_I)
      ##1 PERIPH_IN_O.external_interrupt_three == $past(pin_sync[0])
        && PERIPH_IN_O.psc_in1 == $past(pin_sync[1]);
  endproperty
  a_external_interrupt_three: assert property (p_external_interrupt_three) else $error("external_interrupt_three route wrong"); // R10 R12

  property p_psc;
    @(posedge CLOCK_I) disable iff (RESET_I)
      PERIPH_I.psc_en |=> PIN_OE_O[0] && PIN_O[0] == $past(PERIPH_I.psc_val);
  endproperty
  a_psc: assert property (p_psc) else $error("psc out wrong"); // R11 R15

  property p_dac;
    @(posedge CLOCK_I) disable iff (RESET_I)
      PERIPH_I.dac_en |=> !PIN_OE_O[7] && !DIN_EN_O[7];
  endproperty
  a_dac: assert property (p_dac) else $error("dac override wrong"); // R14

  property p_din3;
    @(posedge CLOCK_I) disable iff (RESET_I)
      PERIPH_I.external_interrupt_three_en |=> DIN_EN_O[0];
  endproperty
  a_din3: assert property (p_din3) else $error("external_interrupt_three din wrong"); // R15

  c_slave: cover property (@(posedge CLOCK_I) PERIPH_IN_O.spi_sel);
  c_psc:   cover property (@(posedge CLOCK_I) PERIPH_I.psc_en ##1 PIN_OE_O[0]);
  c_pchg:  cover property (@(posedge CLOCK_I) PIN_CHANGE_O != 8'h00);
  c_dac:   cover property (@(posedge CLOCK_I) PERIPH_I.dac_en);
endmodule

// File: testbench/pcm_pin_model.sv
// Package pin and external party model for the port C mux
`timescale 1ns/10ps
module pcm_pin_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_oe_i,
  output logic      [7:0] pin_o
);
  logic [7:0] flt_q = 8'h55;

  always_ff @(posedge clk_i)
  begin
    flt_q <= ~flt_q;
  end

  // External master holds select low to pick the slave
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (oe_i[i])
        pin_o[i] = drv_i[i];
      else if (ext_oe_i[i])
        pin_o[i] = ext_val_i[i];
      else if (pullup_i[i])
        pin_o[i] = 1'b1;
      else
        pin_o[i] = flt_q[i];
    end
  end
endmodule

// File: testbench/pcm_mux_tb.sv
// Self-checking bench for the port C mux
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module pcm_mux_tb;
  import pcm_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  pcm_port_t   port = '0;
  pcm_periph_t per = '0;
  logic [7:0]  ext_val = 8'h00;
  logic [7:0]  pin, p_o, p_oe, pu, din, pval, pchg;
  pcm_in_t     pin_in;
  int          n_fail = 0;
  int          n_checks = 0;

  always #12.5 clk = ~clk;

  pcm_mux pcm_mux_inst (.CLOCK_I(clk), .RESET_I(rst), .PORT_I(port),
    .PERIPH_I(per), .PIN_I(pin), .PIN_O(p_o), .PIN_OE_O(p_oe),
    .PULLUP_O(pu), .DIN_EN_O(din), .PIN_VALUE_O(pval),
    .PIN_CHANGE_O(pchg), .PERIPH_IN_O(pin_in));

  // Software keeps every pin input with pull-up off unless a test says
  pcm_pin_model pcm_pin_model_inst (.clk_i(clk), .drv_i(p_o),
    .oe_i(p_oe), .pullup_i(pu), .ext_val_i(ext_val),
    .ext_oe_i(8'hff), .pin_o(pin));

  task automatic step(input int n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask

  task automatic tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  initial
  begin
    #100us;
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    step(16);
    `CHK({p_oe, pu, pchg}, 24'h0)
    @(posedge clk) rst <= 1'b0;
    step(4);
    $display("test reset done");
    // ---------------------------------------------------------------
    // Pin change lines
    // ---------------------------------------------------------------
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk) ext_val <= ext_val ^ (8'h01 << i);
      step(3);
      `CHK(pchg, 8'h01 << i)
      step(1);
      `CHK(pchg, 8'h00)
    end
    $display("test pin change done");
    // ---------------------------------------------------------------
    // Inputs toward peripherals
    // ---------------------------------------------------------------
    @(posedge clk) ext_val <= 8'h0b;
    step(4);
    `CHK({pin_in.t1_clk, pin_in.can_rx, pin_in.timer_one_capture_alt_input}, 3'b111)
    `CHK(pin_in.t0_clk, 1'b0)
    `CHK(pin_in.external_interrupt_three, 1'b1)
    `CHK(pin_in.psc_in1, 1'b1)
    `CHK(pin_in.ss_n, 1'b1)
    `CHK(pval, 8'h0b)
    $display("test inputs done");
    // ---------------------------------------------------------------
    // Output overrides
    // ---------------------------------------------------------------
    @(posedge clk)
    begin
      port.dir <= 8'h82;
      per.timer_one_compare_b_output_en <= 1'b1;
      per.timer_one_compare_b_output_val <= 1'b1;
      per.psc_en <= 1'b1;
      per.psc_val <= 1'b1;
      per.can_tx_en <= 1'b1;
      per.can_tx_val <= 1'b1;
      per.external_interrupt_three_en <= 1'b1;
      per.adc_dis <= 8'h01;
      per.dac_en <= 1'b1;
    end
    step(1);
    `CHK({p_oe[1], p_o[1]}, 2'b11)
    `CHK({p_oe[0], p_o[0]}, 2'b11)
    `CHK({p_oe[2], p_o[2]}, 2'b11)
    `CHK(din[0], 1'b1)
    `CHK({p_oe[7], din[7]}, 2'b00)
    $display("test overrides done");
    // ---------------------------------------------------------------
    // Alternate slave select
    // ---------------------------------------------------------------
    @(posedge clk)
    begin
      per <= '{spi_en: 1'b1, spi_alt: 1'b1, default: '0};
      port.out <= 8'h02;
      ext_val <= 8'h00;
    end
    step(1);
    `CHK(p_oe[1], 1'b0)
    `CHK(pu[1], 1'b1)
    step(3);
    `CHK(pin_in.spi_sel, 1'b1)
    @(posedge clk) ext_val <= 8'h02;
    step(4);
    `CHK(pin_in.spi_sel, 1'b0)
    @(posedge clk) per.spi_master <= 1'b1;
    step(1);
    `CHK(p_oe[1], 1'b1)
    $display("test slave select done");
    tally_and_finish();
  end
endmodule
